//--- shared/rrsc_cfg.svh
// timing and offset constants for the register read split control block
`ifndef RRSC_CFG_SVH
`define RRSC_CFG_SVH

// -------------------------------------------------------------
// non-split register offsets (byte addresses)
// -------------------------------------------------------------
`define RRSC_OFF_DEV_CTRL 17'h00000
`define RRSC_OFF_DEV_STATUS 17'h00008
`define RRSC_OFF_EEPROM_CD 17'h00010
`define RRSC_OFF_EXT_CTRL 17'h00018
`define RRSC_OFF_MDI_CTRL 17'h00020
`define RRSC_OFF_FC_ADDR_LO 17'h00028
`define RRSC_OFF_FC_ADDR_HI 17'h0002c
`define RRSC_OFF_FC_TYPE 17'h00030
`define RRSC_OFF_VLAN_TYPE 17'h00038
`define RRSC_OFF_FC_TX_TIMER 17'h00170
`define RRSC_OFF_TX_CFG_WORD 17'h00178
`define RRSC_OFF_RX_CFG_WORD 17'h00180
`define RRSC_OFF_PKT_BUF_ALLOC 17'h01000
`define RRSC_OFF_INT_CAUSE_RD 17'h000c0
`define RRSC_OFF_INT_CAUSE_SET 17'h000c8
`define RRSC_OFF_INT_MASK_SET 17'h000d0
`define RRSC_OFF_INT_MASK_CLR 17'h000d8
`define RRSC_OFF_TX_CTRL 17'h00400

// -------------------------------------------------------------
// control register fields and reset values
// -------------------------------------------------------------
`define RRSC_CTRL_DUPLEX_BIT 0
`define RRSC_CTRL_SPEED_LO 8
`define RRSC_CTRL_SPEED_HI 9
`define RRSC_CTRL_FRC_SPEED_BIT 11
`define RRSC_CTRL_FRC_DPLX_BIT 12
`define RRSC_CTRL_RESET 32'h00000009
`define RRSC_EXT_CTRL_RESET 32'h00000000

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define RRSC_CLK_PERIOD_NS 10
`define RRSC_INIT_LAT_NS 160
// longest time: round down, at least one cycle
`define RRSC_INIT_LAT_CYC ((`RRSC_INIT_LAT_NS / `RRSC_CLK_PERIOD_NS) > 0 ? \
  (`RRSC_INIT_LAT_NS / `RRSC_CLK_PERIOD_NS) : 1)

`endif

//--- shared/rrsc_pkg.sv
// types for the register read split control block
package rrsc_pkg;

  typedef enum logic [3:0] {
    RRSC_IDLE = 4'h1,
    RRSC_WAIT_BURST = 4'h2,
    RRSC_FETCH = 4'h4,
    RRSC_COMPLETE = 4'h8
  } rrsc_split_state_type;

  typedef enum logic [1:0] {
    RRSC_ANS_NONE = 2'h0,
    RRSC_ANS_DATA = 2'h1,
    RRSC_ANS_SPLIT = 2'h2
  } rrsc_answer_type;

endpackage

//--- rtl/rrsc_offset_match.sv
// decode of a read offset against the non-split register set
`timescale 1ns/100ps
`include "rrsc_cfg.svh"

module rrsc_offset_match
  import rrsc_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input wire logic [ADDR_W-1:0] offset, // byte offset of the read
  output logic nonSplit // offset is in the critical set
);

  always_comb begin
    case (offset) // R06
      `RRSC_OFF_DEV_CTRL, `RRSC_OFF_DEV_STATUS, `RRSC_OFF_EEPROM_CD,
      `RRSC_OFF_EXT_CTRL, `RRSC_OFF_MDI_CTRL, `RRSC_OFF_FC_ADDR_LO,
      `RRSC_OFF_FC_ADDR_HI, `RRSC_OFF_FC_TYPE, `RRSC_OFF_VLAN_TYPE,
      `RRSC_OFF_FC_TX_TIMER, `RRSC_OFF_TX_CFG_WORD,
      `RRSC_OFF_RX_CFG_WORD, `RRSC_OFF_PKT_BUF_ALLOC,
      `RRSC_OFF_INT_CAUSE_RD, `RRSC_OFF_INT_CAUSE_SET,
      `RRSC_OFF_INT_MASK_SET, `RRSC_OFF_INT_MASK_CLR,
      `RRSC_OFF_TX_CTRL: begin
        nonSplit = 1'b1; // R03
      end
      default: begin
        nonSplit = 1'b0;
      end
    endcase
  end

endmodule // rrsc_offset_match

//--- rtl/rrsc_read_split.sv
// register read split control: immediate or split answer per read
`timescale 1ns/100ps
`include "rrsc_cfg.svh"

// Operation
// R01 - general register reads answer split, complete later; a read split while the sequencer is busy is never completed
// R02 - split completion may wait for data burst
// R03 - critical registers complete without split
// R04 - force option splits every register read
// R05 - control registers set modes, link may override
// R06 - decode offset, choose answer within initial latency
module rrsc_read_split
  import rrsc_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 32
) (
  input wire logic mclk, // bus clock
  input wire logic rst, // synchronous reset, active high
  input wire logic forceAllReadSplits, // eeprom option, latched
  input wire logic rdReq, // read request strobe
  input wire logic [ADDR_W-1:0] rdOffset, // byte offset of the read
  output logic rdDataValid, // immediate data answer pulse
  output logic rdSplit, // split response pulse
  output logic [DATA_W-1:0] rdData, // immediate read data
  input wire logic burstActive, // own data burst in progress
  output logic complReq, // split completion wanted
  input wire logic complGrant, // bus accepts the completion
  output logic [DATA_W-1:0] complData, // split completion data
  output logic regReq, // slow internal register fetch
  output logic [ADDR_W-1:0] regOffset, // offset of slow fetch
  input wire logic regAck, // slow fetch done
  input wire logic [DATA_W-1:0] regData, // slow fetch data
  input wire logic fastWr, // write strobe to control regs
  input wire logic [ADDR_W-1:0] fastWrOffset, // write offset
  input wire logic [DATA_W-1:0] fastWrData, // write data
  input wire logic [DATA_W-1:0] fastRdData, // data of other fast regs
  input wire logic linkUp, // phy resolution valid
  input wire logic linkFullDuplex, // resolved duplex
  input wire logic [1:0] linkSpeed, // resolved speed
  output logic duplexSelect, // effective duplex
  output logic [1:0] speedSelect // effective speed
);

  // -------------------------------------------------------------
  // option latch and offset decode
  // -------------------------------------------------------------
  logic forceLatched;
  logic matchFast;
  logic takeFast;
  logic [DATA_W-1:0] devCtrl;
  logic [DATA_W-1:0] extendedControlReg;
  rrsc_split_state_type state;

  // option is resampled only in idle cycles with no read, so a read in
  // flight never sees it change under it
  always_ff @(posedge mclk) begin
    if (rst) begin
      forceLatched <= 1'b0;
    end else if (state == RRSC_IDLE && !rdReq) begin
      forceLatched <= forceAllReadSplits; // R04
    end
  end

  rrsc_offset_match #(.ADDR_W(ADDR_W)) uMatch (
    .offset(rdOffset),
    .nonSplit(matchFast)
  );

  assign takeFast = matchFast && !forceLatched; // R03 R04

  // -------------------------------------------------------------
  // immediate answer, one cycle after request
  // -------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdDataValid <= 1'b0;
      rdSplit <= 1'b0;
      rdData <= '0;
    end else begin
      rdDataValid <= rdReq && takeFast; // R06
      // a busy splitter also answers split; host retries later
      rdSplit <= rdReq && !takeFast; // R01
      if (rdReq && takeFast) begin
        if (rdOffset == `RRSC_OFF_DEV_CTRL) begin
          rdData <= devCtrl;
        end else if (rdOffset == `RRSC_OFF_EXT_CTRL) begin
          rdData <= extendedControlReg;
        end else begin
          rdData <= fastRdData;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // split completion sequencer
  // -------------------------------------------------------------
  logic acceptSplit;
  assign acceptSplit = rdReq && !takeFast && state == RRSC_IDLE;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= RRSC_IDLE;
      regOffset <= '0;
      complData <= '0;
    end else begin
      case (state)
        RRSC_IDLE: begin
          if (acceptSplit) begin
            regOffset <= rdOffset;
            state <= RRSC_FETCH; // R01
          end
        end
        RRSC_FETCH: begin
          if (regAck) begin
            complData <= regData;
            state <= RRSC_WAIT_BURST;
          end
        end
        RRSC_WAIT_BURST: begin
          if (!burstActive) begin
            state <= RRSC_COMPLETE; // R02
          end
        end
        RRSC_COMPLETE: begin
          if (complGrant) begin
            state <= RRSC_IDLE;
          end
        end
        default: begin
          state <= RRSC_IDLE;
        end
      endcase
    end
  end

  assign regReq = state == RRSC_FETCH;
  assign complReq = state == RRSC_COMPLETE && !burstActive; // R02

  // -------------------------------------------------------------
  // control registers and mode resolution
  // -------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      devCtrl <= `RRSC_CTRL_RESET;
      extendedControlReg <= `RRSC_EXT_CTRL_RESET;
    end else if (fastWr) begin
      if (fastWrOffset == `RRSC_OFF_DEV_CTRL) begin
        devCtrl <= fastWrData; // R05
      end
      if (fastWrOffset == `RRSC_OFF_EXT_CTRL) begin
        extendedControlReg <= fastWrData; // R05
      end
    end
  end

  // forced settings win, as do the devCtrl bits while the link is down; otherwise the phy resolution overrides
  always_ff @(posedge mclk) begin
    if (rst) begin
      duplexSelect <= 1'b0;
      speedSelect <= 2'h0;
    end else begin
      if (devCtrl[`RRSC_CTRL_FRC_DPLX_BIT] || !linkUp) begin
        duplexSelect <= devCtrl[`RRSC_CTRL_DUPLEX_BIT]; // R05
      end else begin
        duplexSelect <= linkFullDuplex; // R05
      end
      if (devCtrl[`RRSC_CTRL_FRC_SPEED_BIT] || !linkUp) begin
        speedSelect <= devCtrl[`RRSC_CTRL_SPEED_HI:`RRSC_CTRL_SPEED_LO];
      end else begin
        speedSelect <= linkSpeed; // R05
      end
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  localparam int LAT = `RRSC_INIT_LAT_CYC;

  a_split_general: assert property (@(posedge mclk) disable iff (rst) // R01
    rdReq && !matchFast |=> rdSplit && !rdDataValid)
    else $error("general register read not split");

  a_fast_answer: assert property (@(posedge mclk) disable iff (rst) // R03
    rdReq && matchFast && !forceLatched |=> rdDataValid && !rdSplit)
    else $error("critical register read was split");

  a_force_split: assert property (@(posedge mclk) disable iff (rst) // R04
    rdReq && forceLatched |=> rdSplit)
    else $error("forced split not honoured");

  a_within_latency: assert property (@(posedge mclk) disable iff (rst) // R06
    rdReq |-> ##[1:LAT] (rdSplit || rdDataValid))
    else $error("no answer within initial latency");

  a_hold_burst: assert property (@(posedge mclk) disable iff (rst) // R02
    burstActive |-> !complReq)
    else $error("completion issued during burst");

  // once in RRSC_WAIT_BURST the sequencer must stay parked there while our own burst runs
  a_burst_wait: assert property (@(posedge mclk) disable iff (rst) // R02
    state == RRSC_WAIT_BURST && burstActive |=> state == RRSC_WAIT_BURST)
    else $error("burst wait left while burst active");

  a_fetch_start: assert property (@(posedge mclk) disable iff (rst) // R01
    acceptSplit |=> regReq && regOffset == $past(rdOffset))
    else $error("split read fetch not started");

  a_compl_data: assert property (@(posedge mclk) disable iff (rst) // R01
    regReq && regAck |=> complData == $past(regData))
    else $error("completion data not captured");

  a_forced_duplex: assert property (@(posedge mclk) disable iff (rst) // R05
    devCtrl[`RRSC_CTRL_FRC_DPLX_BIT] ##1 devCtrl[`RRSC_CTRL_FRC_DPLX_BIT]
    |-> duplexSelect == $past(devCtrl[`RRSC_CTRL_DUPLEX_BIT]))
    else $error("forced duplex not applied");

  c_fast_read: cover property (@(posedge mclk) disable iff (rst)
    rdReq && takeFast ##1 rdDataValid);
  c_split_done: cover property (@(posedge mclk) disable iff (rst)
    acceptSplit ##[1:50] (complReq && complGrant));
  c_burst_wait: cover property (@(posedge mclk) disable iff (rst)
    state == RRSC_WAIT_BURST && burstActive);
  c_forced: cover property (@(posedge mclk) disable iff (rst)
    rdReq && matchFast && forceLatched);

endmodule // rrsc_read_split

//--- test/rrsc_bus_partner.sv
// far-side model: slow register store and completion acceptor
`timescale 1ns/100ps
module rrsc_bus_partner (
  input wire logic mclk, // bus clock
  input wire logic rst, // synchronous reset
  input wire logic slow, // answer late instead of promptly
  input wire logic regReq, // fetch wanted
  input wire logic [16:0] regOffset, // fetch offset
  output logic regAck, // fetch done pulse
  output logic [31:0] regData, // fetch data
  input wire logic complReq, // completion wanted
  output logic complGrant // completion accepted pulse
);
  int waitCnt;
  always_ff @(posedge mclk) begin
    regAck <= 1'b0;
    complGrant <= 1'b0;
    // data is not held outside the acknowledge cycle
    regData <= ~regData;
    if (rst) begin
      waitCnt <= 0;
      regData <= 32'h0;
    end else if ((regReq || complReq) && !regAck && !complGrant) begin
      if (waitCnt >= (slow ? 12 : 1)) begin
        waitCnt <= 0;
        if (regReq) begin
          regAck <= 1'b1;
          regData <= {15'h0, regOffset} ^ 32'hc0de0000;
        end else begin
          complGrant <= 1'b1;
        end
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule // rrsc_bus_partner

//--- test/test_rrsc_read_split.sv
// self-checking bench for the register read split control block
`timescale 1ns/100ps
module test_rrsc_read_split;
  import rrsc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic forceAllReadSplits = 1'b0, rdReq = 1'b0, burstActive = 1'b0;
  logic [16:0] rdOffset = 17'h0, fastWrOffset = 17'h0, regOffset;
  logic fastWr = 1'b0, linkUp = 1'b0, linkFullDuplex = 1'b0;
  logic [1:0] linkSpeed = 2'h0, speedSelect;
  logic [31:0] fastWrData = 32'h0, fastRdData = 32'h1234abcd;
  logic [31:0] rdData, complData, regData;
  logic rdDataValid, rdSplit, complReq, complGrant, regReq, regAck;
  logic duplexSelect;
  int fail_count = 0, cmp_count = 0;
  logic [16:0] fastTab [18] = '{17'h00000, 17'h00008, 17'h00010, 17'h00018,
    17'h00020, 17'h00028, 17'h0002c, 17'h00030, 17'h00038, 17'h00170,
    17'h00178, 17'h00180, 17'h01000, 17'h000c0, 17'h000c8, 17'h000d0,
    17'h000d8, 17'h00400};

  always #5 mclk = ~mclk;

  rrsc_read_split u_dut (.mclk(mclk), .rst(rst),
    .forceAllReadSplits(forceAllReadSplits), .rdReq(rdReq),
    .rdOffset(rdOffset), .rdDataValid(rdDataValid), .rdSplit(rdSplit),
    .rdData(rdData), .burstActive(burstActive), .complReq(complReq),
    .complGrant(complGrant), .complData(complData), .regReq(regReq),
    .regOffset(regOffset), .regAck(regAck), .regData(regData),
    .fastWr(fastWr), .fastWrOffset(fastWrOffset), .fastWrData(fastWrData),
    .fastRdData(fastRdData), .linkUp(linkUp), .linkFullDuplex(linkFullDuplex),
    .linkSpeed(linkSpeed), .duplexSelect(duplexSelect),
    .speedSelect(speedSelect));

  rrsc_bus_partner u_partner (.mclk(mclk), .rst(rst), .slow(slow),
    .regReq(regReq), .regOffset(regOffset), .regAck(regAck),
    .regData(regData), .complReq(complReq), .complGrant(complGrant));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // after return the answer cycle is what is sampled
  task automatic read_req(logic [16:0] off);
    rdOffset <= off;
    rdReq <= 1'b1;
    @(posedge mclk);
    rdReq <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic fast_reads();
    foreach (fastTab[i]) begin
      read_req(fastTab[i]);
      chk("fast valid", 32'h1, {31'h0, rdDataValid});
      chk("fast split", 32'h0, {31'h0, rdSplit});
      if (i == 0) chk("ctrl reset", 32'h00000009, rdData);
      else if (i == 3) chk("ext reset", 32'h0, rdData);
      else chk("fast data", fastRdData, rdData);
    end
  endtask

  // a second split read while one is pending is answered, never completed
  task automatic split_read(logic [16:0] off, logic burst, logic extra);
    int n;
    burstActive <= burst;
    read_req(off);
    chk("split", 32'h1, {31'h0, rdSplit});
    chk("no data", 32'h0, {31'h0, rdDataValid});
    chk("fetch offset", {15'h0, off}, {15'h0, regOffset});
    if (extra) begin
      read_req(17'h04010);
      chk("refused split", 32'h1, {31'h0, rdSplit});
    end
    if (burst) begin
      repeat (30) begin
        @(posedge mclk);
        chk("held by burst", 32'h0, {31'h0, complReq});
      end
      burstActive <= 1'b0;
    end
    for (n = 0; n < 200 && complGrant !== 1'b1; n++) @(posedge mclk);
    if (n == 200) begin
      fail_count++;
      end_of_test();
    end
    chk("compl data", {15'h0, off} ^ 32'hc0de0000, complData);
    repeat (20) begin
      @(posedge mclk);
      chk("no queued compl", 32'h0, {31'h0, complReq | regReq});
    end
  endtask

  task automatic mode_chk(logic [31:0] ctrl, logic dup, logic [1:0] spd);
    fastWrOffset <= 17'h0;
    fastWrData <= ctrl;
    fastWr <= 1'b1;
    @(posedge mclk);
    fastWr <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("duplex", {31'h0, dup}, {31'h0, duplexSelect});
    chk("speed", {30'h0, spd}, {30'h0, speedSelect});
  endtask

  task automatic ext_rw(logic [31:0] val);
    fastWrOffset <= 17'h00018;
    fastWrData <= val;
    fastWr <= 1'b1;
    @(posedge mclk);
    fastWr <= 1'b0;
    read_req(17'h00018);
    chk("ext readback", val, rdData);
    chk("ext valid", 32'h1, {31'h0, rdDataValid});
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("duplex reset", 32'h1, {31'h0, duplexSelect});
    fast_reads();
    slow <= 1'b1;
    split_read(17'h04000, 1'b1, 1'b1);
    slow <= 1'b0;
    split_read(17'h02410, 1'b0, 1'b0);
    forceAllReadSplits <= 1'b1;
    repeat (3) @(posedge mclk);
    split_read(17'h00000, 1'b0, 1'b0);
    split_read(17'h000c0, 1'b0, 1'b0);
    forceAllReadSplits <= 1'b0;
    linkUp <= 1'b1;
    linkSpeed <= 2'h2;
    mode_chk(32'h00000000, 1'b0, 2'h2);
    mode_chk(32'h00001901, 1'b1, 2'h1);
    linkUp <= 1'b0;
    mode_chk(32'h00000000, 1'b0, 2'h0);
    ext_rw(32'h5a5a00ff);
    end_of_test();
  end
endmodule // test_rrsc_read_split
